// File: core/space_decode_pkg.sv
// constants and types for the memory space map and address decode block
package space_decode_pkg;

	// ----------------------------------------------------------------
	// register window offsets (low address byte)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PAGE      = 8'he0;
	localparam logic [7:0] OFS_SPACE_MAP = 8'he2;
	localparam logic [7:0] OFS_PWR_ZERO  = 8'hb0;
	localparam logic [7:0] OFS_PWR_TWO   = 8'hb4;

	// ----------------------------------------------------------------
	// code/data space map fields
	// ----------------------------------------------------------------
	localparam int SM_PERIPHERAL_IO_ENABLE     = 7;
	localparam int SM_PF_DATA    = 4;
	localparam int SM_SF_DATA    = 3;
	localparam int SM_PF_CODE    = 2;
	localparam int SM_SF_CODE    = 1;
	localparam int SM_SRAM_CODE  = 0;
	localparam logic [7:0] SM_USED_MASK = 8'h9f;
	localparam logic [7:0] SM_SEPARATE  = 8'h0c;

	// ----------------------------------------------------------------
	// power control fields and reset values
	// ----------------------------------------------------------------
	localparam int PC0_FAST = 3;
	localparam logic [7:0] PWR0_RESET = 8'h08;
	localparam logic [7:0] PWR2_RESET = 8'h00;
	localparam logic [7:0] PWR2_USED_MASK = 8'h1f;
	localparam int PC2_BLK_RST = 4;

	// ----------------------------------------------------------------
	// standby timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STANDBY_NS    = 70;
	localparam logic [3:0] STANDBY_CYC =
		4'((STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// logic array input vector layout
	// ----------------------------------------------------------------
	localparam int V_ADDR = 0;
	localparam int V_PROGRAM_FETCH_STROBE = 16;
	localparam int V_RD   = 17;
	localparam int V_WR   = 18;
	localparam int V_ALE  = 19;
	localparam int V_RST  = 20;
	localparam int V_PDN  = 21;
	localparam int V_PA   = 22;
	localparam int V_PB   = 30;
	localparam int V_PC   = 38;
	localparam int V_PD   = 42;
	localparam int V_PG   = 44;
	localparam int V_FB1  = 52;
	localparam int V_FB2  = 60;
	localparam int V_RDY  = 68;
	localparam int VEC_W  = 69;

	// ----------------------------------------------------------------
	// product term layout of the decode array
	// ----------------------------------------------------------------
	localparam int N_PRI    = 4;
	localparam int N_SEC    = 2;
	localparam int N_PER    = 2;
	localparam int PT_FLASH = 3;
	localparam int PT_SRAM  = 2;
	localparam int T_PRI    = 0;
	localparam int T_SEC    = 12;
	localparam int T_SRAM   = 18;
	localparam int T_WIN    = 20;
	localparam int T_PER    = 21;
	localparam int N_TERMS  = 23;
	localparam int PIN_W    = 24;

	typedef enum logic [2:0] {
		ST_LOAD    = 3'b001,
		ST_ACTIVE  = 3'b010,
		ST_STANDBY = 3'b100
	} state_t;

	typedef struct packed {
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
		logic             pkg52;
		logic [7:0]       page;
		logic [7:0]       space_map;
		logic [7:0]       pwr0;
		logic [7:0]       pwr2;
		state_t           st;
		logic [3:0]       idle_cnt;
		logic [VEC_W-1:0] held;
		logic [N_PRI-1:0] pri_en;
		logic [N_SEC-1:0] sec_en;
		logic             sram_en;
		logic             win_sel;
		logic [N_PER-1:0] per_sel;
		logic [VEC_W-1:0] gen;
		logic [7:0]       rd_data;
		logic             rd_oe;
	} core_state_t;

endpackage : space_decode_pkg

// File: core/space_decode.sv
// memory space map, page register and decode logic array
// Notes on behaviour
// - space map in register window; boot value from config; rewritable
// - each flash enabled separately for fetch and data by its map bits; SRAM data always, fetch by bit 0
// - bits 2 and 4 together put primary flash in both spaces
// - eight-bit page register, read and write at window offset E0h
// - page bits are inputs to the decode array terms
// - page bits are also passed to the general logic array
// - address, strobes, reset, power-down, ports, page, feedback, ready
// - port A inputs are withheld in the 52-pin package
// - fast bit clear: arrays go standby after inputs idle about 70ns
// - four power control bits block strobes, a fifth blocks reset; only unused ones get blocked
// - four primary sector selects, up to three terms each
// - two secondary sector selects, up to three terms each
// - one SRAM select of two terms plus a register window select
// - two peripheral selects, used only in peripheral I/O mode
// - configured equations act from power-up without software setup
// - secondary beats primary; SRAM, window and peripherals beat flash
// - SRAM enabled only while its select is high
`timescale 1ns/100ps
module space_decode
	import space_decode_pkg::*;
(
	input  wire logic                     I_CLK,
	input  wire logic                     I_RSTN,
	input  wire logic [15:0]              i_addr,
	input  wire logic                     i_program_fetch_strobe,
	input  wire logic                     i_read_strobe,
	input  wire logic                     i_write_strobe,
	input  wire logic                     i_addr_latch_strobe,
	input  wire logic [7:0]               i_data,
	input  wire logic                     i_reset_pin,
	input  wire logic                     i_power_down_input,
	input  wire logic [7:0]               i_port_a,
	input  wire logic [7:0]               i_port_b,
	input  wire logic [3:0]               i_port_c,
	input  wire logic [1:0]               i_port_d,
	input  wire logic [7:0]               i_macrocell_group_one_feedback,
	input  wire logic [7:0]               i_macrocell_group_two_feedback,
	input  wire logic                     i_flash_ready,
	input  wire logic                     i_cfg_package_52pin,
	input  wire logic [7:0]               i_cfg_space_map,
	input  wire logic [N_TERMS*VEC_W-1:0] i_cfg_term_mask,
	input  wire logic [N_TERMS*VEC_W-1:0] i_cfg_term_value,
	output logic [7:0]                    o_data,
	output logic                          o_data_oe,
	output logic [N_PRI-1:0]              o_primary_sector_enable,
	output logic [N_SEC-1:0]              o_secondary_sector_enable,
	output logic                          o_sram_enable,
	output logic                          o_register_window_select,
	output logic [N_PER-1:0]              o_peripheral_select,
	output logic [7:0]                    o_page_bits,
	output logic [VEC_W-1:0]              o_general_array_inputs,
	output logic                          o_array_standby
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one product term: every cared-for input equals its value
	function automatic logic term_hit(
		input logic [VEC_W-1:0] vec,
		input logic [VEC_W-1:0] mask,
		input logic [VEC_W-1:0] val
	);
		term_hit = &((vec ~^ val) | ~mask);
	endfunction : term_hit

	core_state_t        s_r;
	core_state_t        s_nxt;
	logic [3:0]         strobe_eff;
	logic [7:0]         porta_eff;
	logic [VEC_W-1:0]   live;
	logic [VEC_W-1:0]   dec;
	logic [N_TERMS-1:0] hits;
	logic [N_PRI-1:0]   pri_sel;
	logic [N_SEC-1:0]   sec_sel;
	logic               sram_sel;
	logic               win_sel;
	logic [N_PER-1:0]   per_sel;
	logic               high_sel;
	logic               any_data;
	logic               wr_hit;
	logic               rd_hit;
	logic               changed;
	logic [7:0]         reg_rd;

	// ----------------------------------------------------------------
	// logic array input vector
	// ----------------------------------------------------------------
	assign strobe_eff = {i_addr_latch_strobe, i_write_strobe,
		i_read_strobe, i_program_fetch_strobe} & ~s_r.pwr2[3:0];
	assign porta_eff = s_r.pkg52 ? 8'h00 : s_r.pin_s2[7:0];
	assign live = {i_flash_ready,
		i_macrocell_group_two_feedback,
		i_macrocell_group_one_feedback,
		s_r.page,
		s_r.pin_s2[21:20], s_r.pin_s2[19:16], s_r.pin_s2[15:8],
		porta_eff,
		s_r.pin_s2[23],
		s_r.pin_s2[22] & ~s_r.pwr2[PC2_BLK_RST],
		strobe_eff, i_addr};
	// standby holds the old snapshot, costing one cycle on wake-up
	assign dec = (s_r.st == ST_STANDBY) ? s_r.held : live;
	assign changed = (live != s_r.held);

	// ----------------------------------------------------------------
	// decode array
	// ----------------------------------------------------------------
	// terms come straight from configuration, so valid from power-up
	always_comb begin
		hits = '0;
		for (int i = 0; i < N_TERMS; i++) begin
			hits[i] = term_hit(dec, i_cfg_term_mask[i*VEC_W +: VEC_W],
				i_cfg_term_value[i*VEC_W +: VEC_W]);
		end
		for (int i = 0; i < N_PRI; i++) begin
			pri_sel[i] = |hits[T_PRI + i*PT_FLASH +: PT_FLASH];
		end
		for (int i = 0; i < N_SEC; i++) begin
			sec_sel[i] = |hits[T_SEC + i*PT_FLASH +: PT_FLASH];
		end
	end

	assign sram_sel = |hits[T_SRAM +: PT_SRAM];
	assign win_sel  = hits[T_WIN];
	assign per_sel  = hits[T_PER +: N_PER]
		& {N_PER{s_r.space_map[SM_PERIPHERAL_IO_ENABLE]}};
	assign high_sel = sram_sel | win_sel | (|per_sel);
	assign any_data = i_read_strobe | i_write_strobe;

	// ----------------------------------------------------------------
	// register window access
	// ----------------------------------------------------------------
	assign wr_hit = win_sel & i_write_strobe & (s_r.st != ST_LOAD);
	assign rd_hit = win_sel & i_read_strobe;

	always_comb begin
		case (i_addr[7:0])
			OFS_PAGE:      reg_rd = s_r.page;
			OFS_SPACE_MAP: reg_rd = s_r.space_map & SM_USED_MASK;
			OFS_PWR_ZERO:  reg_rd = s_r.pwr0;
			OFS_PWR_TWO:   reg_rd = s_r.pwr2 & PWR2_USED_MASK;
			default:       reg_rd = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pin_s1 = {i_power_down_input, i_reset_pin, i_port_d,
			i_port_c, i_port_b, i_port_a};
		s_nxt.pin_s2 = s_r.pin_s1;
		if (wr_hit) begin
			case (i_addr[7:0])
				OFS_PAGE:      s_nxt.page = i_data;
				OFS_SPACE_MAP: s_nxt.space_map = i_data & SM_USED_MASK;
				OFS_PWR_ZERO:  s_nxt.pwr0 = i_data;
				OFS_PWR_TWO:   s_nxt.pwr2 = i_data & PWR2_USED_MASK;
				default:       s_nxt.page = s_r.page;
			endcase
		end
		s_nxt.rd_oe = rd_hit;
		s_nxt.rd_data = rd_hit ? reg_rd : 8'h00;
		case (s_r.st)
			ST_LOAD: begin
				// boot value of the map and strap caught once after reset
				s_nxt.space_map = i_cfg_space_map & SM_USED_MASK;
				s_nxt.pkg52 = i_cfg_package_52pin;
				s_nxt.held = live;
				s_nxt.idle_cnt = 4'h0;
				s_nxt.st = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				s_nxt.held = live;
				if (s_r.pwr0[PC0_FAST] || changed) begin
					s_nxt.idle_cnt = 4'h0;
				end else if (s_r.idle_cnt == STANDBY_CYC - 4'h1) begin
					s_nxt.idle_cnt = 4'h0;
					s_nxt.st = ST_STANDBY;
				end else begin
					s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
				end
			end
			ST_STANDBY: begin
				if (s_r.pwr0[PC0_FAST] || changed) begin
					s_nxt.st = ST_ACTIVE;
				end
			end
			default: s_nxt.st = ST_LOAD;
		endcase
		// memory gating with priority
		for (int i = 0; i < N_PRI; i++) begin
			s_nxt.pri_en[i] = pri_sel[i] & ~high_sel & ~(|sec_sel) &
				((i_program_fetch_strobe & s_r.space_map[SM_PF_CODE]) |
				(any_data & s_r.space_map[SM_PF_DATA]));
		end
		for (int i = 0; i < N_SEC; i++) begin
			s_nxt.sec_en[i] = sec_sel[i] & ~high_sel &
				((i_program_fetch_strobe & s_r.space_map[SM_SF_CODE]) |
				(any_data & s_r.space_map[SM_SF_DATA]));
		end
		s_nxt.sram_en = sram_sel & (any_data |
			(i_program_fetch_strobe & s_r.space_map[SM_SRAM_CODE]));
		s_nxt.win_sel = win_sel & any_data;
		s_nxt.per_sel = per_sel & {N_PER{any_data}};
		s_nxt.gen = dec;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			s_r <= '0;
			s_r.st <= ST_LOAD;
			s_r.pwr0 <= PWR0_RESET;
			s_r.pwr2 <= PWR2_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_data = s_r.rd_data;
	assign o_data_oe = s_r.rd_oe;
	assign o_primary_sector_enable = s_r.pri_en;
	assign o_secondary_sector_enable = s_r.sec_en;
	assign o_sram_enable = s_r.sram_en;
	assign o_register_window_select = s_r.win_sel;
	assign o_peripheral_select = s_r.per_sel;
	assign o_page_bits = s_r.page;
	assign o_general_array_inputs = s_r.gen;
	assign o_array_standby = (s_r.st == ST_STANDBY);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_page_write: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(wr_hit && i_addr[7:0] == OFS_PAGE) |=> (s_r.page == $past(i_data))
	) else $error("page register did not take the written byte");

	a_map_boot_load: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(s_r.st == ST_LOAD) |=>
			(s_r.space_map == ($past(i_cfg_space_map) & SM_USED_MASK))
	) else $error("space map did not load its boot value");

	a_pri_code_gate: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(i_program_fetch_strobe && !any_data && !s_r.space_map[SM_PF_CODE])
			|=> (o_primary_sector_enable == '0)
	) else $error("fetch reached primary flash while disallowed");

	a_flash_prio: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(o_sram_enable || o_register_window_select || (|o_peripheral_select)
			|| (|o_secondary_sector_enable)) |-> (o_primary_sector_enable == '0)
	) else $error("primary flash enabled under a higher select");

	a_periph_mode: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(|o_peripheral_select) |-> $past(s_r.space_map[SM_PERIPHERAL_IO_ENABLE])
	) else $error("peripheral select outside peripheral mode");

	a_standby_entry: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(s_r.st == ST_ACTIVE && !s_r.pwr0[PC0_FAST] && !changed
			&& s_r.idle_cnt == STANDBY_CYC - 4'h1) |=> o_array_standby
	) else $error("arrays did not enter standby after idle time");

	a_standby_wake: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(o_array_standby && (changed || s_r.pwr0[PC0_FAST]))
			|=> !o_array_standby
	) else $error("arrays stayed in standby on input change");

	a_strobe_block: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		o_general_array_inputs[V_PROGRAM_FETCH_STROBE] |-> !$past(s_r.pwr2[0])
	) else $error("blocked fetch strobe reached the logic arrays");

	a_port_a_hidden: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(s_r.pkg52 && $past(s_r.pkg52))
			|-> (o_general_array_inputs[V_PA +: 8] == 8'h00)
	) else $error("port A reached the arrays in the small package");

	a_sram_gate: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		!sram_sel |=> !o_sram_enable
	) else $error("SRAM enabled without its select");

	a_sec_data_gate: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(any_data && !i_program_fetch_strobe && !s_r.space_map[SM_SF_DATA])
			|=> (o_secondary_sector_enable == '0)
	) else $error("data cycle reached secondary flash while disallowed");

	a_page_read: assert property (
		@(posedge I_CLK) disable iff (!I_RSTN)
		(rd_hit && i_addr[7:0] == OFS_PAGE)
			|=> (o_data_oe && (o_data == $past(s_r.page)))
	) else $error("page register read returned a wrong byte");

endmodule : space_decode

// File: dv/mcu_bus_model.sv
// bus model of the controller core that drives the decode block
`timescale 1ns/100ps
module mcu_bus_model (
	input  wire logic [1:0] i_op,
	input  wire logic       i_ale_req,
	output logic            o_fetch,
	output logic            o_read,
	output logic            o_write,
	output logic            o_ale
);
	// one of fetch, read and write at a time: the core never overlaps fetch and data cycles
	assign o_fetch = (i_op == 2'd1);
	assign o_read  = (i_op == 2'd2);
	assign o_write = (i_op == 2'd3);
	// no equation uses the latch strobe, so software may block it
	assign o_ale   = i_ale_req;
endmodule : mcu_bus_model

// File: dv/testbench.sv
// self-checking bench for the space map and decode block
`timescale 1ns/100ps
module testbench;
	import space_decode_pkg::*;
	logic                     clk, rst_n, strap, ale_req, ale, fetch, rd, wr;
	logic                     ready, o_oe, o_sram, o_win, o_stby, quiet;
	logic [15:0]              addr;
	logic [1:0]               op, o_sec, o_per;
	logic [3:0]               o_pri;
	logic [7:0]               wdata, pa, fb1, fb2, cfg_map, o_data, o_page;
	logic [7:0]               m_page, m_map, m_pc0, m_pc2, exp_pg;
	logic [N_TERMS*VEC_W-1:0] tmask, tval;
	logic [VEC_W-1:0]         o_vec, exp_vec;
	logic [9:0]               exp_sel;
	logic [8:0]               exp_rd;
	logic [31:0]              seed;
	logic [7:0]               pb;
	logic [3:0]               pc;
	logic [1:0]               pd;
	logic                     rpin, pdn_pin;
	logic [15:0]              pin_q1, pin_q2;
	int                       n_fail, cmp_count;
	bit                       cmp_on;
	logic [7:0]               ofs [5] = '{8'he0, 8'he2, 8'hb0, 8'hb4, 8'h55};

	mcu_bus_model mcu_bus_model_i (.i_op(op), .i_ale_req(ale_req),
		.o_fetch(fetch), .o_read(rd), .o_write(wr), .o_ale(ale));
	space_decode space_decode_i (
		.I_CLK(clk), .I_RSTN(rst_n), .i_addr(addr),
		.i_program_fetch_strobe(fetch), .i_read_strobe(rd),
		.i_write_strobe(wr), .i_addr_latch_strobe(ale), .i_data(wdata),
		.i_reset_pin(rpin), .i_power_down_input(pdn_pin), .i_port_a(pa),
		.i_port_b(pb), .i_port_c(pc), .i_port_d(pd),
		.i_macrocell_group_one_feedback(fb1),
		.i_macrocell_group_two_feedback(fb2), .i_flash_ready(ready),
		.i_cfg_package_52pin(strap), .i_cfg_space_map(cfg_map),
		.i_cfg_term_mask(tmask), .i_cfg_term_value(tval),
		.o_data(o_data), .o_data_oe(o_oe),
		.o_primary_sector_enable(o_pri), .o_secondary_sector_enable(o_sec),
		.o_sram_enable(o_sram), .o_register_window_select(o_win),
		.o_peripheral_select(o_per), .o_page_bits(o_page),
		.o_general_array_inputs(o_vec), .o_array_standby(o_stby));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// compare and helper tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [VEC_W-1:0] g, input logic [VEC_W-1:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic chk_sel(input logic [9:0] g, input logic [9:0] e);
		cmp(VEC_W'(g), VEC_W'(e));
	endtask : chk_sel
	task automatic chk_reg(input logic [8:0] g, input logic [8:0] e);
		cmp(VEC_W'(g), VEC_W'(e));
	endtask : chk_reg
	task automatic chk_vec(input logic [VEC_W-1:0] g,
		input logic [VEC_W-1:0] e);
		cmp(g, e);
	endtask : chk_vec
	task automatic chk_bit(input logic g, input logic e);
		cmp(VEC_W'(g), VEC_W'(e));
	endtask : chk_bit
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic set_term(input int t, input logic [VEC_W-1:0] m, v);
		tmask[t*VEC_W +: VEC_W] = m;
		tval[t*VEC_W +: VEC_W] = v;
	endtask : set_term

	// one bus cycle at the falling edge; the model predicts the next edge
	task automatic drive(input logic [15:0] a, input logic [1:0] o,
		input logic [7:0] d);
		logic [31:0] r;
		logic [3:0]  ps;
		logic [1:0]  ss, pe;
		logic        sr, wn, hi, dt, f, w;
		@(negedge clk);
		if (cmp_on) begin
			chk_sel({o_pri, o_sec, o_sram, o_win, o_per},
				exp_sel);
			chk_reg({o_oe, o_data}, exp_rd);
			chk_reg({1'b0, o_page}, {1'b0, exp_pg});
			chk_vec(o_vec, exp_vec);
			chk_bit(o_stby, 1'b0);
		end
		if (!quiet) begin
			r = rnd();
			{ready, fb2, fb1, ale_req} = r[17:0];
			r = rnd();
			{pdn_pin, rpin, pd, pc, pb} = r[15:0];
		end
		addr = a;
		op = o;
		wdata = d;
		f = (o == 2'd1);
		w = (o == 2'd3);
		dt = (o == 2'd2) | w;
		for (int i = 0; i < 4; i++) ps[i] = (a[15:14] == 2'(i));
		for (int j = 0; j < 2; j++) ss[j] = (a[15:13] == 3'(4 + j)) && m_page[0];
		for (int k = 0; k < 2; k++) pe[k] = (a[15:8] == 8'(254 - k)) && m_map[7];
		sr = (a[15:11] == 5'h10);
		wn = (a[15:8] == 8'hff);
		hi = sr | wn | (|pe);
		exp_sel[9:6] = ps & {4{~hi & ~|ss & (f & m_map[2] | dt & m_map[4])}};
		exp_sel[5:4] = ss & {2{~hi & (f & m_map[1] | dt & m_map[3])}};
		exp_sel[3:0] = {sr & (dt | f & m_map[0]), wn & dt, pe & {2{dt}}};
		// pin inputs pass two sync stages, so they lag the bus by two calls
		exp_vec = {ready, fb2, fb1, m_page, pin_q2[13:0],
			strap ? 8'h00 : pa, pin_q2[15], pin_q2[14] & ~m_pc2[4],
			{ale_req, w, dt & ~w, f} & ~m_pc2[3:0], a};
		pin_q2 = pin_q1;
		pin_q1 = {pdn_pin, rpin, pd, pc, pb};
		exp_rd = 9'h000;
		if (wn && o == 2'd2) begin
			case (a[7:0])
				8'he0: exp_rd = {1'b1, m_page};
				8'he2: exp_rd = {1'b1, m_map};
				8'hb0: exp_rd = {1'b1, m_pc0};
				8'hb4: exp_rd = {1'b1, m_pc2};
				default: exp_rd = 9'h100;
			endcase
		end
		if (wn && w) begin
			case (a[7:0])
				8'he0: m_page = d;
				8'he2: m_map = d & 8'h9f;
				8'hb0: m_pc0 = d;
				8'hb4: m_pc2 = d & 8'h1f;
				default: ;
			endcase
		end
		exp_pg = m_page;
	endtask : drive

	task automatic rand_run(input int n);
		logic [31:0] r;
		logic [15:0] a;
		logic [1:0]  o;
		logic [7:0]  d;
		for (int c = 0; c < n; c++) begin
			r = rnd();
			o = r[1:0];
			d = r[15:8];
			case (r[3:2])
				2'd0: a = r[31:16];
				2'd1: a = {8'hff, ofs[r[18:16] % 5]};
				2'd2: a = {6'h3f, r[17:16], r[31:24]};
				default: a = {3'b100, r[31:19]};
			endcase
			// keep fast mode and leave page ff free for the unused terms
			if (a == 16'hffb0 && o == 2'd3) o = 2'd2;
			if (a[7:0] == 8'he0) d[7] = 1'b0;
			drive(a, o, d);
		end
	endtask : rand_run

	task automatic do_reset(input logic s, input logic [7:0] cm, pin_a);
		@(negedge clk);
		cmp_on = 0;
		rst_n = 1'b0;
		{strap, cfg_map, pa} = {s, cm, pin_a};
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		{m_page, m_map, m_pc0, m_pc2} = {8'h00, cm & 8'h9f, 8'h08, 8'h00};
		repeat (4) drive(16'h0000, 2'd0, 8'h00);
		cmp_on = 1;
	endtask : do_reset

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, addr, op, wdata, ale_req, fb1, fb2, ready, quiet} = '0;
		{strap, cfg_map, pa, n_fail, cmp_count, cmp_on} = '0;
		{pb, pc, pd, rpin, pdn_pin, pin_q1, pin_q2} = '0;
		seed = 32'd47799;
		for (int t = 0; t < N_TERMS; t++)
			set_term(t, VEC_W'(8'hff) << V_PG, VEC_W'(8'hff) << V_PG);
		for (int i = 0; i < 4; i++)
			set_term(3 * i, VEC_W'(16'hc000), VEC_W'(i) << 14);
		for (int j = 0; j < 2; j++)
			set_term(12 + 3 * j, VEC_W'(16'he000) | (VEC_W'(1) << V_PG),
				VEC_W'(16'h8000 + 16'h2000 * j) | (VEC_W'(1) << V_PG));
		set_term(T_SRAM, VEC_W'(16'hf800), VEC_W'(16'h8000));
		set_term(T_WIN, VEC_W'(16'hff00), VEC_W'(16'hff00));
		for (int k = 0; k < 2; k++)
			set_term(T_PER + k, VEC_W'(16'hff00), VEC_W'(16'hfe00 - 16'h100 * k));
		do_reset(1'b0, 8'h12, 8'ha5);
		for (int i = 0; i < 5; i++) drive({8'hff, ofs[i]}, 2'd2, 8'h00);
		drive(16'hffe2, 2'd3, 8'h0c);
		rand_run(3000);
		// turbo off: inputs held still must put the arrays to sleep
		drive(16'hffb0, 2'd3, 8'h00);
		{quiet, cmp_on} = 2'b10;
		repeat (14) drive(16'h1234, 2'd0, 8'h00);
		chk_bit(o_stby, 1'b1);
		// the first cycle only wakes the arrays, so the write lands next
		repeat (2) drive(16'hffb0, 2'd3, 8'h08);
		cmp_on = 1'b1;
		repeat (10) drive(16'h1234, 2'd0, 8'h00);
		chk_bit(o_stby, 1'b0);
		quiet = 1'b0;
		do_reset(1'b1, 8'h94, 8'h3c);
		rand_run(1000);
		summarize();
	end

	initial begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule : testbench
